// File: rtl/psl_pkg.sv
// ************************************************************
// Constants of the parameter set loader
// ************************************************************
package psl_pkg;

    // Register bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // Register offsets (word index on the plain port)
    localparam logic [3:0] OFS_LOAD_CODE  = 4'h0;
    localparam logic [3:0] OFS_STORE_CODE = 4'h1;
    localparam logic [3:0] OFS_STATUS     = 4'h2;
    localparam logic [3:0] OFS_INPUT_FUNC = 4'h3;
    localparam logic [3:0] OFS_LOAD_POL   = 4'h4;

    // Set codes as seen by software
    localparam int         CODE_W       = 3;
    localparam logic [2:0] CODE_FACTORY = 3'h0;
    localparam logic [2:0] CODE_SET1    = 3'h1;
    localparam logic [2:0] CODE_MAX     = 3'h4;

    // Function assigned to one digital input (two bits each)
    localparam logic [1:0] FUNC_NONE = 2'h0;
    localparam logic [1:0] FUNC_SEL  = 2'h1;
    localparam logic [1:0] FUNC_LOAD = 2'h2;

    // Status register fields
    localparam int STAT_SET_LSB = 0;
    localparam int STAT_BUSY    = 3;
    localparam int STAT_UNSAVED = 4;
    localparam int STAT_READY   = 5;

    // Reset values
    localparam logic [31:0] RST_INPUT_FUNC = 32'h0000_0000;
    localparam logic        RST_LOAD_POL   = 1'h1;

    // Timing: control lockout after a terminal load
    localparam int CLK_HZ       = 100_000_000;
    localparam int HOLD_TIME_MS = 1000;
    localparam int HOLD_CYCLES  = HOLD_TIME_MS * (CLK_HZ / 1000);

    // Default size of one parameter set and number of inputs
    localparam int NUM_PARAMS = 16;
    localparam int NUM_INPUTS = 4;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_XFER = 3'h2,
        ST_HOLD = 3'h4
    } psl_state_type;

endpackage

// File: rtl/psl_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Raw pin levels in, synchronised levels out
// ************************************************************
interface psl_sync_if #(
    parameter int W = 1
);
    logic [W-1:0] raw;
    logic [W-1:0] sync;

    modport sink (input raw, output sync);
    modport user (output raw, input sync);
endinterface
`default_nettype wire

// File: rtl/psl_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Two-stage synchroniser for pin levels
// ************************************************************
module psl_sync (
    input wire logic  sys_clk,
    input wire logic  sys_rst,
    psl_sync_if.sink  port
);
    localparam int W = $bits(port.raw);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= port.raw;
            sync_q <= meta_q;
        end
    end

    assign port.sync = sync_q;
endmodule
`default_nettype wire

// File: rtl/psl_loader.sv
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - After reset set 1 is loaded before any other load or store is acted on.
// - Select inputs form a binary index, low bit first, 00 = set 1.
// - At most two inputs act as select inputs; extra ones are ignored.
// - The lowest-numbered select input is the low bit, next the high.
// - A select other than set 1 at power-up starts a load of that set.
// - An active load input while inhibited loads the selected set.
// - After the last parameter the status shows the loaded set.
// - A terminal load ignores controls and drops ready for about 1 s.
// - The load code starts a load: 0 factory, 1 to 4 a set; reads 0 when done.
// - The power-up terminal set is loaded after the set 1 load.
// - Unstored changes are discarded and overwritten by a load.
module psl_loader
    import psl_pkg::*;
#(
    parameter  int N_IN     = NUM_INPUTS,
    parameter  int N_PARAMS = NUM_PARAMS,
    parameter  int HOLD_CNT = HOLD_CYCLES,
    // Index width is needed by a port, so it lives up here
    localparam int PW       = (N_PARAMS > 1) ? $clog2(N_PARAMS) : 1
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic [N_IN-1:0]   din_raw,
    input  wire logic              inhibit_raw,
    input  wire logic              param_changed,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    output logic                   ready,
    output logic                   load_active,
    output logic      [CODE_W-1:0] load_set,
    output logic      [PW-1:0]     load_param_idx,
    output logic                   load_param_we,
    output logic                   store_req,
    output logic      [CODE_W-1:0] store_set,
    output logic      [CODE_W-1:0] loaded_set
);
    // Lockout counter wide enough for the full one-second count;
    // a short count in simulation shrinks it to a few bits
    localparam int HW = $clog2(HOLD_CNT + 1);
    localparam logic [PW-1:0] PIDX_LAST = PW'(N_PARAMS - 1);
    localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CNT - 1);

    // ********************************************************
    // Pin synchronisation
    // ********************************************************
    // Inhibit rides in the top bit, so one synchroniser serves all
    // pins. Bits settle one by one, not as a word: a select that
    // moves together with the load level may be seen a cycle late,
    // which is why selects have to lead the load level.
    psl_sync_if #(.W(N_IN + 1)) pins ();

    assign pins.raw = {inhibit_raw, din_raw};

    // Every pin passes two flops before use
    psl_sync u_sync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .port    (pins)
    );

    logic [N_IN-1:0] din;
    logic            inhibit;

    assign din     = pins.sync[N_IN-1:0];
    assign inhibit = pins.sync[N_IN];

    // ********************************************************
    // Register state
    // ********************************************************
    psl_state_type       state_q;
    logic [CODE_W-1:0]   code_q;
    logic [PW-1:0]       pidx_q;
    logic [HW-1:0]       hold_q;
    logic                term_q;
    logic                boot_q;
    logic                rearm_q;
    logic [CODE_W-1:0]   loaded_q;
    logic                unsaved_q;
    logic [2*N_IN-1:0]   func_q;
    logic                pol_q;
    logic                store_q;
    logic [CODE_W-1:0]   store_set_q;
    logic [DATA_W-1:0]   rdata_q;

    // ********************************************************
    // Input function decode
    // ********************************************************
    logic       sel_lo;
    logic       sel_hi;
    logic       load_lvl;
    logic [1:0] sel_cnt;

    // Scan upward so the lowest select input wins the low bit
    always_comb begin
        sel_lo   = 1'b0;
        sel_hi   = 1'b0;
        load_lvl = 1'b0;
        sel_cnt  = 2'h0;
        for (int i = 0; i < N_IN; i++) begin
            if (func_q[2*i +: 2] == FUNC_SEL) begin
                if (sel_cnt == 2'h0) begin
                    sel_lo  = din[i];
                    sel_cnt = 2'h1;
                end else if (sel_cnt == 2'h1) begin
                    sel_hi  = din[i];
                    sel_cnt = 2'h2;
                end
            end
            if (func_q[2*i +: 2] == FUNC_LOAD) begin
                load_lvl = load_lvl | (din[i] == pol_q);
            end
        end
    end

    // Select inputs 00 give set 1, low bit first
    logic [CODE_W-1:0] sel_code;

    assign sel_code = CODE_W'({sel_hi, sel_lo}) + CODE_SET1;

    // ********************************************************
    // Start conditions
    // ********************************************************
    logic idle;
    logic xfer_end;
    logic code_wr;
    logic code_ok;
    logic start_code;
    logic start_term;

    assign idle     = (state_q == ST_IDLE);
    assign xfer_end = (state_q == ST_XFER) && (pidx_q == PIDX_LAST);
    assign code_wr  = reg_wr && (reg_addr == OFS_LOAD_CODE);
    assign code_ok  = (reg_wdata[CODE_W-1:0] <= CODE_MAX)
                   && (reg_wdata[DATA_W-1:CODE_W] == '0);

    // Software load wins over a terminal load in the same cycle.
    // The load input is a level, so a pin left active would reload
    // forever; rearm_q blocks it until the level has gone away.
    assign start_code = idle && code_wr && code_ok;
    // Level sensed, only while inhibited
    assign start_term = idle && !start_code && load_lvl
                     && inhibit && !rearm_q;

    // ********************************************************
    // Load sequencer
    // ********************************************************
    // Reset enters a set 1 transfer straight away
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= ST_XFER;
            code_q  <= CODE_SET1;
            pidx_q  <= '0;
            hold_q  <= '0;
            term_q  <= 1'b0;
            boot_q  <= 1'b1;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    pidx_q <= '0;
                    hold_q <= '0;
                    if (start_code) begin
                        state_q <= ST_XFER;
                        code_q  <= reg_wdata[CODE_W-1:0];
                        term_q  <= 1'b0;
                    end else if (start_term) begin
                        state_q <= ST_XFER;
                        code_q  <= sel_code;
                        term_q  <= 1'b1;
                    end
                end
                ST_XFER: begin
                    pidx_q <= pidx_q + PW'(1);
                    if (xfer_end) begin
                        pidx_q <= '0;
                        // Selects are read at the end of the set 1
                        // load, so software has that long to map them
                        if (boot_q && sel_code != CODE_SET1) begin
                            // Extra power-up step
                            boot_q  <= 1'b0;
                            code_q  <= sel_code;
                            state_q <= ST_XFER;
                        end else if (term_q) begin
                            boot_q  <= 1'b0;
                            state_q <= ST_HOLD;
                        end else begin
                            boot_q  <= 1'b0;
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_HOLD: begin
                    // All controls ignored until the count runs out;
                    // a code load has no lockout, only terminal loads
                    hold_q <= hold_q + HW'(1);
                    if (hold_q == HOLD_LAST) begin
                        hold_q  <= '0;
                        term_q  <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ********************************************************
    // Load input rearm
    // ********************************************************
    // A held level must drop before it loads again; set wins
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rearm_q <= 1'b0;
        end else if (start_term) begin
            rearm_q <= 1'b1;
        end else if (!load_lvl) begin
            rearm_q <= 1'b0;
        end
    end

    // ********************************************************
    // Loaded set status
    // ********************************************************
    // Published only once the last parameter is written
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            loaded_q <= CODE_FACTORY;
        end else if (xfer_end) begin
            loaded_q <= code_q;
        end
    end

    // Edits since the last store or load; a new edit wins, since
    // losing it would hide a change that no stored set holds yet
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            unsaved_q <= 1'b0;
        end else if (param_changed) begin
            unsaved_q <= 1'b1;
        end else if (xfer_end || store_q) begin
            unsaved_q <= 1'b0;
        end
    end

    // ********************************************************
    // Configuration registers
    // ********************************************************
    // Input function map and load polarity
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            func_q <= RST_INPUT_FUNC[2*N_IN-1:0];
            pol_q  <= RST_LOAD_POL;
        end else if (reg_wr && reg_addr == OFS_INPUT_FUNC) begin
            func_q <= reg_wdata[2*N_IN-1:0];
        end else if (reg_wr && reg_addr == OFS_LOAD_POL) begin
            pol_q  <= reg_wdata[0];
        end
    end

    // Store request pulse towards parameter storage; refused while
    // a load runs, as the active values are half overwritten then
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            store_q     <= 1'b0;
            store_set_q <= CODE_SET1;
        end else begin
            store_q <= 1'b0;
            if (idle && reg_wr && reg_addr == OFS_STORE_CODE
                && reg_wdata[CODE_W-1:0] >= CODE_SET1
                && reg_wdata[CODE_W-1:0] <= CODE_MAX
                && reg_wdata[DATA_W-1:CODE_W] == '0) begin
                store_q     <= 1'b1;
                store_set_q <= reg_wdata[CODE_W-1:0];
            end
        end
    end

    // ********************************************************
    // Register read port
    // ********************************************************
    // Data stand one cycle after the strobe, zero otherwise
    // Zero when idle keeps a shared read bus free of stale data
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= '0;
            if (reg_rd) begin
                unique case (reg_addr)
                    OFS_LOAD_CODE: begin
                        // Code falls back to 0 when done
                        if (!idle && !term_q) begin
                            rdata_q[CODE_W-1:0] <= code_q;
                        end
                    end
                    OFS_STORE_CODE: begin
                        rdata_q[CODE_W-1:0] <= store_set_q;
                    end
                    OFS_STATUS: begin
                        rdata_q[STAT_SET_LSB +: CODE_W] <= loaded_q;
                        rdata_q[STAT_BUSY]    <= !idle;
                        rdata_q[STAT_UNSAVED] <= unsaved_q;
                        rdata_q[STAT_READY]   <= idle;
                    end
                    OFS_INPUT_FUNC: begin
                        rdata_q[2*N_IN-1:0] <= func_q;
                    end
                    OFS_LOAD_POL: begin
                        rdata_q[0] <= pol_q;
                    end
                    default: begin
                        rdata_q <= '0;
                    end
                endcase
            end
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    // Ready withheld for transfer and lockout
    // Straight from the state flop, so no glitch reaches the pin
    assign ready          = idle;
    assign load_active    = !idle;
    // Each transfer overwrites the active values
    assign load_param_we  = (state_q == ST_XFER);
    assign load_set       = code_q;
    assign load_param_idx = pidx_q;
    assign store_req      = store_q;
    assign store_set      = store_set_q;
    assign loaded_set     = loaded_q;
    assign reg_rdata      = rdata_q;

endmodule
`default_nettype wire

// File: testbench/psl_loader_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Port checks of the parameter set loader
// ************************************************************
module psl_loader_sva
    import psl_pkg::*;
#(
    parameter int N_PARAMS = NUM_PARAMS,
    parameter int HOLD_CNT = HOLD_CYCLES,
    parameter int PW       = $clog2(N_PARAMS)
) (
    input wire logic              sys_clk,
    input wire logic              sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              ready,
    input wire logic              load_active,
    input wire logic [CODE_W-1:0] load_set,
    input wire logic [PW-1:0]     load_param_idx,
    input wire logic              load_param_we,
    input wire logic              store_req,
    input wire logic [CODE_W-1:0] store_set,
    input wire logic [CODE_W-1:0] loaded_set
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic [31:0] hold_q;

    // Idle-but-not-ready run length; a code load must show none at all
    always_ff @(posedge sys_clk) begin
        if (sys_rst || ready || load_param_we) begin
            hold_q <= '0;
        end else begin
            hold_q <= hold_q + 32'h1;
        end
    end

    a_boot_set_one: assert property (
        $fell(sys_rst) |-> load_param_we && load_set == CODE_SET1
        && load_param_idx == '0) else $error("boot load is not set 1");
    a_idx_step: assert property (
        load_param_we && load_param_idx != PW'(N_PARAMS - 1) |=>
        load_param_we && load_param_idx == $past(load_param_idx) + 1'b1)
        else $error("transfer index did not step");
    a_loaded_update: assert property (
        load_param_we && load_param_idx == PW'(N_PARAMS - 1) |=>
        loaded_set == $past(load_set)) else $error("loaded set wrong");
    a_busy_not_ready: assert property (
        load_param_we |-> !ready) else $error("ready during transfer");
    a_active_mirror: assert property (
        load_active == !ready) else $error("load_active not !ready");
    a_code_start: assert property (
        reg_wr && reg_addr == OFS_LOAD_CODE && reg_wdata <= 32'h4 && ready
        |=> !ready && load_param_we && load_param_idx == '0
        && load_set == CODE_W'($past(reg_wdata)))
        else $error("code load did not start");
    a_hold_length: assert property (
        $rose(ready) |-> hold_q == 0 || hold_q == HOLD_CNT)
        else $error("lockout length wrong");
    a_store_pulse: assert property (
        reg_wr && reg_addr == OFS_STORE_CODE && reg_wdata inside {[1:4]}
        && ready |=> store_req && store_set == CODE_W'($past(reg_wdata))
        ##1 !store_req) else $error("store pulse wrong");
endmodule

bind psl_loader psl_loader_sva #(
    .N_PARAMS(N_PARAMS), .HOLD_CNT(HOLD_CNT)
) u_sva (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .ready(ready),
    .load_active(load_active), .load_set(load_set),
    .load_param_idx(load_param_idx), .load_param_we(load_param_we),
    .store_req(store_req), .store_set(store_set), .loaded_set(loaded_set)
);
`default_nettype wire

// File: testbench/psl_term_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Control terminals: select, spare select, load and inhibit
// ************************************************************
module psl_term_model (
    input  wire logic       sys_clk,
    input  wire logic [1:0] want_sel,
    input  wire logic       want_extra,
    input  wire logic       want_load,
    input  wire logic       want_inh,
    output logic      [3:0] din_raw,
    output logic            inhibit_raw
);
    // Load level rises only once the selects already show the wanted set,
    // and then holds even if the selects move during the load; pins start
    // unknown, which the loader's reset flushes from its synchroniser
    always @(posedge sys_clk) begin
        din_raw[1:0] <= want_sel;
        din_raw[3]   <= want_extra;
        din_raw[2]   <= want_load &&
                        (din_raw[2] || din_raw[1:0] == want_sel);
        inhibit_raw  <= want_inh;
    end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Bench for the parameter set loader
// ************************************************************
module tb_top
    import psl_pkg::*;
;
    localparam int NP   = 16;
    localparam int HOLD = 20;
    logic              sys_clk = 1'b0;
    logic              sys_rst;
    logic [1:0]        want_sel;
    logic              want_extra;
    logic              want_load;
    logic              want_inh;
    logic              param_changed;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic              ready;
    logic [CODE_W-1:0] load_set;
    logic [CODE_W-1:0] loaded_set;
    logic              load_param_we;
    logic [3:0]        din_raw;
    logic              inhibit_raw;
    int                failures = 0;
    int                compares = 0;

    always #5 sys_clk = ~sys_clk;

    psl_term_model term (.sys_clk(sys_clk), .want_sel(want_sel),
        .want_extra(want_extra), .want_load(want_load),
        .want_inh(want_inh), .din_raw(din_raw), .inhibit_raw(inhibit_raw));
    // Short lockout so a terminal load fits the run
    psl_loader #(.N_IN(4), .N_PARAMS(NP), .HOLD_CNT(HOLD)) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .din_raw(din_raw),
        .inhibit_raw(inhibit_raw), .param_changed(param_changed),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ready(ready),
        .load_active(), .load_set(load_set), .load_param_idx(),
        .load_param_we(load_param_we), .store_req(), .store_set(),
        .loaded_set(loaded_set));

    task automatic wrap_up();
        if (failures == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Counts edges until ready shows lvl; a dead design ends the run
    task automatic wait_lvl(input logic lvl, input int lim, output int n);
        n = 0;
        while (ready !== lvl) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n > lim) begin
                failures++;
                wrap_up();
            end
        end
    endtask

    // Selects are assigned while the boot transfer of set 1 still runs
    task automatic t_boot();
        int seen3;
        seen3 = 0;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1;
        check("boot set", load_set, CODE_SET1);
        wr(OFS_INPUT_FUNC, 32'h0000_0065);
        for (int i = 0; i < 40; i++) begin
            @(posedge sys_clk);
            #1;
            seen3 |= (load_param_we === 1'b1 && load_set === 3'h3);
        end
        check("boot extra", seen3, 1);
        check("boot loaded", loaded_set, 3'h3);
    endtask

    // Selects move right after the start; the sampled set must win
    task automatic t_term(input logic [1:0] sel);
        int n;
        @(posedge sys_clk);
        want_sel  <= sel;
        want_inh  <= 1'b1;
        want_load <= 1'b1;
        wait_lvl(1'b0, 10, n);
        want_sel <= ~sel;
        wait_lvl(1'b1, NP + HOLD + 5, n);
        check("lockout", n, NP + HOLD);
        check("term set", loaded_set, sel + 3'h1);
        want_load <= 1'b0;
        want_inh  <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic t_code();
        logic [31:0] d;
        int          n;
        for (int c = 0; c <= 4; c++) begin
            @(posedge sys_clk);
            param_changed <= 1'b1;
            @(posedge sys_clk);
            param_changed <= 1'b0;
            rd(OFS_STATUS, d);
            check("unsaved", d[STAT_UNSAVED], 1'b1);
            wr(OFS_LOAD_CODE, c);
            #1;
            check("code busy", ready, 1'b0);
            wait_lvl(1'b1, NP + 5, n);
            check("code len", n, NP);
            rd(OFS_STATUS, d);
            check("status", d[5:0], {3'b100, c[2:0]});
            rd(OFS_LOAD_CODE, d);
            check("code back", d, 32'h0);
        end
    endtask

    initial begin
        logic [31:0] d;
        int          n;
        sys_rst = 1'b1;
        want_sel = 2'b10;
        want_extra = 1'b1;
        want_load = 1'b0;
        want_inh = 1'b0;
        param_changed = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        t_boot();
        for (int s = 0; s < 4; s++) begin
            t_term(s[1:0]);
        end
        // Load level without inhibit must do nothing
        @(posedge sys_clk);
        want_load <= 1'b1;
        repeat (8) @(posedge sys_clk);
        #1;
        check("no inhibit", ready, 1'b1);
        want_load <= 1'b0;
        t_code();
        wr(OFS_LOAD_CODE, 32'h5);
        #1;
        check("code 5", ready, 1'b1);
        wr(OFS_STORE_CODE, 32'h2);
        rd(OFS_STORE_CODE, d);
        check("store set", d, 32'h2);
        rd(4'hF, d);
        check("unmapped", d, 32'h0);
        rd(OFS_INPUT_FUNC, d);
        check("func map", d, 32'h65);
        // Low-active load level: the idle pin loads once inhibited
        wr(OFS_LOAD_POL, 32'h0);
        rd(OFS_LOAD_POL, d);
        check("load pol", d, 32'h0);
        want_inh <= 1'b1;
        wait_lvl(1'b0, 10, n);
        wait_lvl(1'b1, NP + HOLD + 5, n);
        check("low pol hold", n, NP + HOLD);
        check("low pol set", loaded_set, CODE_SET1);
        wrap_up();
    end
endmodule
`default_nettype wire
